// ==== spm_pkg.sv ====
// Constants, register layouts and enumerations of the power state manager.
// Assumes a 250 MHz system clock and a plain byte-addressed register port.
package spm_pkg;

  // Clock rate and the one-second time base
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYC = TICK_S * CLK_MHZ * 1000000;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam int unsigned BTN_HOLD_S = 4;

  // Register byte offsets
  localparam int AW = 8;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_TMO = 8'h04;
  localparam logic [AW-1:0] A_DEV = 8'h08;
  localparam logic [AW-1:0] A_MON = 8'h0C;
  localparam logic [AW-1:0] A_WAKE = 8'h10;
  localparam logic [AW-1:0] A_ALRM = 8'h14;
  localparam logic [AW-1:0] A_STAT = 8'h18;
  localparam logic [AW-1:0] A_ISTS = 8'h1C;
  localparam logic [AW-1:0] A_IMSK = 8'h20;

  // Modes and states
  typedef enum logic [1:0] {PM_OFF, PM_ON, PM_INST} spm_pm_e;
  typedef enum logic [1:0] {PD_NONE, PD_STBY, PD_SUSP} spm_pd_e;
  typedef enum logic [1:0] {MON_NONE, MON_STBY, MON_SUSP, MON_OFF} spm_mon_e;
  typedef enum logic [1:0] {ST_ON, ST_STBY, ST_SUSP, ST_OFF} spm_st_e;

  // Register layouts
  typedef struct packed {
    logic [22:0] rsv;
    logic [2:0] thr;
    spm_mon_e mon;
    spm_pd_e hdd;
    spm_pd_e vid;
  } spm_dev_s;
  typedef struct packed {
    logic [23:0] rsv;
    logic [3:0] susp;
    logic [3:0] stby;
  } spm_tmo_s;
  typedef struct packed {
    logic [28:0] rsv;
    logic btn_onoff;
    logic alarm_en;
    logic ring_en;
  } spm_wake_s;
  typedef struct packed {
    logic [2:0] rsv3;
    logic [4:0] day;
    logic [2:0] rsv2;
    logic [4:0] hour;
    logic [1:0] rsv1;
    logic [5:0] min;
    logic [1:0] rsv0;
    logic [5:0] sec;
  } spm_alrm_s;

  // Writable bits of each register
  localparam logic [31:0] DEV_WM = 32'h0000_01FF;
  localparam logic [31:0] TMO_WM = 32'h0000_00FF;
  localparam logic [31:0] WAKE_WM = 32'h0000_0007;
  localparam logic [31:0] ALRM_WM = 32'h1F1F_3F3F;

  // Reset values
  localparam logic [2:0] THR_DEF = 3'h4;
  localparam int NSRC = 10;
  localparam logic [NSRC-1:0] MON_DEF = 10'h3F6;
  localparam logic [4:0] ALRM_DAY = 5'h0F;
  localparam logic [4:0] ALRM_HOUR = 5'h0C;
  localparam logic [5:0] ALRM_MIN = 6'h32;
  localparam logic [5:0] ALRM_SEC = 6'h1E;

  // Interrupt status bits
  localparam int IRQ_W = 5;
  localparam int EV_STBY = 0;
  localparam int EV_SUSP = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_OFF = 3;
  localparam int EV_UP = 4;

endpackage

// ==== spm_tmr_if.sv ====
// Link between the manager and one inactivity timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface spm_tmr_if;
  logic sec_tick;
  logic run;
  logic reload;
  logic [3:0] limit;
  logic expired;
  modport ctl (output sec_tick, run, reload, limit, input expired);
  modport tmr (input sec_tick, run, reload, limit, output expired);
endinterface

// ==== spm_sec_tick.sv ====
// One-cycle pulse once per second, divided down from the system clock.
// Assumes a free-running clock; the count is a parameter for simulation.
`timescale 1ns/1ns
module spm_sec_tick #(
  parameter int unsigned CYC = 250000000
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  output logic tick // One pulse per second
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt_r;
  logic tick_r;

  // Divider counter and pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (cnt_r == CW'(CYC - 1));
      if (cnt_r == CW'(CYC - 1)) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
  assign tick = tick_r;
endmodule

// ==== spm_idle_timer.sv ====
// Minute-resolution inactivity timer counted in seconds.
// Assumes sec_tick is a one-cycle pulse; limit 0 disables the timer.
`timescale 1ns/1ns
module spm_idle_timer
  import spm_pkg::*;
#(
  parameter int CW = 10
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  spm_tmr_if.tmr t // Control and expiry
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] target;
  logic done_r;
  logic exp_r;
  logic hit;

  assign target = CW'(t.limit) * CW'(SEC_PER_MIN);
  assign hit = t.run && !t.reload && t.sec_tick && !done_r &&
               (t.limit != '0) && (cnt_r + 1'b1 == target);

  // Count seconds; a reload or stop restarts from zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      done_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      exp_r <= hit;
      if (t.reload || !t.run) begin
        cnt_r <= '0;
        done_r <= 1'b0;
      end else if (t.sec_tick && !done_r) begin
        cnt_r <= cnt_r + 1'b1;
        done_r <= hit;
      end
    end
  end
  assign t.expired = exp_r;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  reload_clear_a: assert property (t.reload |=> cnt_r == '0 && !exp_r)
    else $error("timer not restarted by reload");
  no_exp_off_a: assert property (t.limit == '0 |=> !exp_r)
    else $error("disabled timer expired");
endmodule

// ==== spm_power_mgr.sv ====
// Power state manager: full on, standby, suspend and soft off.
// Assumes all inputs synchronous to clock and a plain register port.
`timescale 1ns/1ns

// Function
// - In full on, inactivity for the standby timeout enters standby.
// - In standby, inactivity for the suspend timeout enters suspend.
// - Control is enabled, instant-on or disabled; disabled stops timed moves.
// - Each wake source can be monitored or ignored individually.
// - Monitored activity in standby or suspend returns to full on.
// - Monitored activity reloads both inactivity timers.
// - With control enabled, saving states run the processor clock at the selected fraction.
// - Saving states put video into its selected conserving state.
// - Saving states put the hard disk into its selected state.
// - Saving states signal the selected monitor power state.
// - Suspend function: a short press enters suspend.
// - Suspend function: holding over four seconds turns off.
// - On/off function: any press turns the system off.
// - Ring resume enabled: a ring in soft off powers up.
// - Alarm resume enabled: matching day and time powers up.
// - Alarm fields reset to day 15, 12:50:30.
module spm_power_mgr
#(
  parameter int unsigned TICK_CYCLES = spm_pkg::TICK_CYC
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [spm_pkg::AW-1:0] addr, // Register byte address
  input wire logic [31:0] wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rd_data, // Read data, cycle after rd_en
  input wire logic [spm_pkg::NSRC-1:0] irq_lines, // Activity lines
  input wire logic pwr_btn, // Power button, high when pressed
  input wire logic ring_ind, // Modem ring indication
  input wire logic [4:0] rtc_day, // Clock day of month
  input wire logic [4:0] rtc_hour, // Clock hour
  input wire logic [5:0] rtc_min, // Clock minute
  input wire logic [5:0] rtc_sec, // Clock second
  output spm_pkg::spm_st_e power_state, // Current power state
  output logic sys_on, // Supply enable, low in soft off
  output logic cpu_clk_en, // Processor clock enable
  output spm_pkg::spm_pd_e video_mode, // Video conserving state
  output spm_pkg::spm_pd_e hdd_mode, // Hard disk conserving state
  output spm_pkg::spm_mon_e monitor_saving_state, // Monitor state
  output logic standby_evt, // Pulse on standby entry
  output logic suspend_evt, // Pulse on suspend entry
  output logic irq // Level interrupt
);
  import spm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  spm_pm_e pm_r;
  spm_tmo_s tmo_r;
  spm_dev_s dev_r;
  spm_wake_s wake_r;
  spm_alrm_s alrm_r;
  logic [NSRC-1:0] mon_r;
  logic [IRQ_W-1:0] ists_r;
  logic [IRQ_W-1:0] imsk_r;
  logic [IRQ_W-1:0] ev;
  spm_st_e st_r;
  spm_st_e st_nxt;
  logic sec_tick;
  logic act;
  logic sav;
  logic tmo_wr;
  logic btn_prev_r;
  logic btn_lock_r;
  logic [2:0] btn_sec_r;
  logic btn_rise;
  logic btn_fall;
  logic long_hit;
  logic btn_off;
  logic btn_susp;
  logic btn_on;
  logic ring_hit;
  logic alarm_hit;
  logic [2:0] phase_r;
  logic [31:0] rd_data_r;
  spm_st_e state_o_r;
  logic sys_on_r;
  logic cpu_clk_en_r;
  spm_pd_e vid_o_r;
  spm_pd_e hdd_o_r;
  spm_mon_e mon_o_r;
  logic stby_evt_r;
  logic susp_evt_r;
  logic irq_r;

  spm_tmr_if stby_t ();
  spm_tmr_if susp_t ();

  ////////////////////////////////////////////////////////////////////////
  // Time base and timers
  spm_sec_tick #(.CYC(TICK_CYCLES)) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick(sec_tick)
  );

  spm_idle_timer u_stby (
    .clock(clock),
    .rst_n(rst_n),
    .t(stby_t)
  );

  spm_idle_timer u_susp (
    .clock(clock),
    .rst_n(rst_n),
    .t(susp_t)
  );

  // Only monitored lines count as activity
  assign act = |(irq_lines & mon_r);
  assign sav = (st_r == ST_STBY) || (st_r == ST_SUSP);
  assign tmo_wr = wr_en && (addr == A_TMO);

  // The standby timer runs only in full on, the suspend timer only in standby, both with management on
  assign stby_t.sec_tick = sec_tick;
  assign stby_t.run = (pm_r != PM_OFF) && (st_r == ST_ON);
  assign stby_t.reload = act || tmo_wr;
  assign stby_t.limit = tmo_r.stby;
  assign susp_t.sec_tick = sec_tick;
  assign susp_t.run = (pm_r != PM_OFF) && (st_r == ST_STBY);
  assign susp_t.reload = act || tmo_wr;
  assign susp_t.limit = tmo_r.susp;

  ////////////////////////////////////////////////////////////////////////
  // Power button and wake sources
  assign btn_rise = pwr_btn && !btn_prev_r;
  assign btn_fall = !pwr_btn && btn_prev_r;
  assign long_hit = pwr_btn && sec_tick && (btn_sec_r == 3'(BTN_HOLD_S));
  assign btn_off = !btn_lock_r && (st_r != ST_OFF) &&
                   (wake_r.btn_onoff ? btn_rise : long_hit);
  assign btn_susp = !btn_lock_r && !wake_r.btn_onoff && btn_fall &&
                    (btn_sec_r < 3'(BTN_HOLD_S)) &&
                    (st_r != ST_OFF) && (st_r != ST_SUSP);
  assign btn_on = !btn_lock_r && btn_rise && (st_r == ST_OFF);
  assign ring_hit = wake_r.ring_en && ring_ind;
  assign alarm_hit = wake_r.alarm_en && (rtc_day == alrm_r.day) &&
                     (rtc_hour == alrm_r.hour) &&
                     (rtc_min == alrm_r.min) &&
                     (rtc_sec == alrm_r.sec);

  // Held seconds; the lock keeps one press from acting twice
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      btn_prev_r <= 1'b0;
      btn_lock_r <= 1'b0;
      btn_sec_r <= '0;
    end else begin
      btn_prev_r <= pwr_btn;
      if (!pwr_btn) begin
        btn_lock_r <= 1'b0;
      end else if (btn_off || btn_on) begin
        btn_lock_r <= 1'b1;
      end
      if (btn_rise) begin
        btn_sec_r <= '0;
      end else if (pwr_btn && sec_tick && btn_sec_r != '1) begin
        btn_sec_r <= btn_sec_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power state machine
  // Button requests outrank wake events and timers
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_ON: begin
        if (btn_off) begin
          st_nxt = ST_OFF;
        end else if (btn_susp) begin
          st_nxt = ST_SUSP;
        end else if (stby_t.expired && pm_r != PM_OFF) begin
          st_nxt = ST_STBY;
        end
      end
      ST_STBY: begin
        if (btn_off) begin
          st_nxt = ST_OFF;
        end else if (btn_susp) begin
          st_nxt = ST_SUSP;
        end else if (act) begin
          st_nxt = ST_ON;
        end else if (susp_t.expired && pm_r != PM_OFF) begin
          st_nxt = ST_SUSP;
        end
      end
      ST_SUSP: begin
        if (btn_off) begin
          st_nxt = ST_OFF;
        end else if (act) begin
          st_nxt = ST_ON;
        end
      end
      ST_OFF: begin
        if (ring_hit || alarm_hit || btn_on) begin
          st_nxt = ST_ON;
        end
      end
      default: st_nxt = ST_ON;
    endcase
  end

  // State register; power-on reset lands in full on
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_ON;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Device outputs
  // Throttle phase: the processor runs thr+1 of every eight cycles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + 1'b1;
    end
  end

  // State, supply and event outputs follow the next state so they track st_r
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_o_r <= ST_ON;
      sys_on_r <= 1'b1;
      cpu_clk_en_r <= 1'b1;
      vid_o_r <= PD_NONE;
      hdd_o_r <= PD_NONE;
      mon_o_r <= MON_NONE;
      stby_evt_r <= 1'b0;
      susp_evt_r <= 1'b0;
    end else begin
      state_o_r <= st_nxt;
      sys_on_r <= (st_nxt != ST_OFF);
      // Instant-on keeps full speed to wake faster
      cpu_clk_en_r <= !(sav && pm_r == PM_ON) ||
                      (phase_r <= dev_r.thr);
      vid_o_r <= sav ? dev_r.vid : PD_NONE;
      hdd_o_r <= sav ? dev_r.hdd : PD_NONE;
      mon_o_r <= sav ? dev_r.mon : MON_NONE;
      stby_evt_r <= (st_nxt == ST_STBY) && (st_r != ST_STBY);
      susp_evt_r <= (st_nxt == ST_SUSP) && (st_r != ST_SUSP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file
  // Reserved bits are masked so they always read back as zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pm_r <= PM_OFF;
      tmo_r <= '0;
      dev_r <= '{rsv: '0, thr: THR_DEF, mon: MON_STBY, hdd: PD_NONE,
                 vid: PD_STBY};
      mon_r <= MON_DEF;
      wake_r <= '0;
      alrm_r <= '{rsv3: '0, day: ALRM_DAY, rsv2: '0, hour: ALRM_HOUR,
                  rsv1: '0, min: ALRM_MIN, rsv0: '0, sec: ALRM_SEC};
      imsk_r <= '0;
    end else if (wr_en) begin
      case (addr)
        A_CTRL: pm_r <= spm_pm_e'(wr_data[1:0]);
        A_TMO: tmo_r <= spm_tmo_s'(wr_data & TMO_WM);
        A_DEV: dev_r <= spm_dev_s'(wr_data & DEV_WM);
        A_MON: mon_r <= wr_data[NSRC-1:0];
        A_WAKE: wake_r <= spm_wake_s'(wr_data & WAKE_WM);
        A_ALRM: alrm_r <= spm_alrm_s'(wr_data & ALRM_WM);
        A_IMSK: imsk_r <= wr_data[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Events; a new event wins over a clear in the same cycle
  assign ev[EV_STBY] = (st_nxt == ST_STBY) && (st_r != ST_STBY);
  assign ev[EV_SUSP] = (st_nxt == ST_SUSP) && (st_r != ST_SUSP);
  assign ev[EV_WAKE] = sav && (st_nxt == ST_ON);
  assign ev[EV_OFF] = (st_nxt == ST_OFF) && (st_r != ST_OFF);
  assign ev[EV_UP] = (st_r == ST_OFF) && (st_nxt == ST_ON);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ists_r <= '0;
    end else if (wr_en && addr == A_ISTS) begin
      ists_r <= (ists_r & ~wr_data[IRQ_W-1:0]) | ev;
    end else begin
      ists_r <= ists_r | ev;
    end
  end

  // Interrupt level, one cycle behind the status bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(ists_r & imsk_r);
    end
  end

  // Read data stands for one cycle only; unmapped reads give zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= '0;
      if (rd_en) begin
        case (addr)
          A_CTRL: rd_data_r <= 32'(pm_r);
          A_TMO: rd_data_r <= tmo_r;
          A_DEV: rd_data_r <= dev_r;
          A_MON: rd_data_r <= 32'(mon_r);
          A_WAKE: rd_data_r <= wake_r;
          A_ALRM: rd_data_r <= alrm_r;
          A_STAT: rd_data_r <= {29'h0000_0000, pwr_btn, st_r};
          A_ISTS: rd_data_r <= 32'(ists_r);
          A_IMSK: rd_data_r <= 32'(imsk_r);
          default: rd_data_r <= '0;
        endcase
      end
    end
  end

  assign rd_data = rd_data_r;
  assign power_state = state_o_r;
  assign sys_on = sys_on_r;
  assign cpu_clk_en = cpu_clk_en_r;
  assign video_mode = vid_o_r;
  assign hdd_mode = hdd_o_r;
  assign monitor_saving_state = mon_o_r;
  assign standby_evt = stby_evt_r;
  assign suspend_evt = susp_evt_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  stby_entry_a: assert property (st_r == ST_ON && stby_t.expired &&
    pm_r != PM_OFF && !btn_off && !btn_susp |=> st_r == ST_STBY &&
    power_state == ST_STBY)
    else $error("standby not entered on timeout");
  susp_entry_a: assert property (st_r == ST_STBY && susp_t.expired &&
    pm_r != PM_OFF && !btn_off && !btn_susp && !act
    |=> st_r == ST_SUSP)
    else $error("suspend not entered on timeout");
  pm_hold_a: assert property (pm_r == PM_OFF && st_r == ST_ON
    |=> st_r != ST_STBY)
    else $error("timed move while management disabled");
  ignored_src_a: assert property (st_r == ST_SUSP &&
    (irq_lines & mon_r) == '0 && !btn_off |=> st_r == ST_SUSP)
    else $error("ignored source woke the system");
  wake_full_a: assert property (sav && act && !btn_off && !btn_susp
    |=> st_r == ST_ON ##1 cpu_clk_en)
    else $error("activity did not wake the system");
  throttle_a: assert property (st_r == ST_SUSP && pm_r == PM_ON &&
    phase_r > dev_r.thr |=> !cpu_clk_en)
    else $error("clock not throttled");
  saving_out_a: assert property (st_r == ST_STBY && !wr_en
    |=> video_mode == dev_r.vid && monitor_saving_state == dev_r.mon &&
    hdd_mode == dev_r.hdd)
    else $error("saving states not applied");
  long_press_a: assert property (long_hit && !btn_lock_r &&
    !wake_r.btn_onoff && st_r != ST_OFF |=> st_r == ST_OFF && !sys_on)
    else $error("long press did not turn off");
  onoff_press_a: assert property (wake_r.btn_onoff && btn_rise &&
    !btn_lock_r && st_r != ST_OFF |=> st_r == ST_OFF)
    else $error("on/off press did not turn off");
  ring_ignore_a: assert property (st_r == ST_OFF && !wake_r.ring_en &&
    !alarm_hit && !btn_on |=> st_r == ST_OFF)
    else $error("ignored ring woke the system");
  alarm_up_a: assert property (st_r == ST_OFF && alarm_hit
    |=> st_r == ST_ON)
    else $error("alarm match did not power up");
  evt_pulse_a: assert property (standby_evt |=> !standby_evt)
    else $error("standby event longer than one cycle");

  wake_c: cover property (st_r == ST_SUSP ##1 st_r == ST_ON);
  stby_c: cover property (st_r == ST_ON && stby_t.expired);
  off_up_c: cover property (st_r == ST_OFF ##1 st_r == ST_ON);
endmodule

// ==== spm_far.sv ====
// Far-side model: activity lines, power button, modem ring and clock time.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ns
module spm_far (
  input wire logic clock, // System clock
  output logic [9:0] irq_lines, // Activity lines
  output logic pwr_btn, // Button, high pressed
  output logic ring_ind, // Modem ring
  output logic [21:0] rtc // Day, hour, minute, second
);
  // Idle levels from time zero
  initial begin
    irq_lines = 10'h000;
    pwr_btn = 1'b0;
    ring_ind = 1'b0;
    rtc = 22'h000000;
  end
  // Activity is a level held for n cycles
  task automatic act(input logic [9:0] b, input int n);
    @(posedge clock) irq_lines <= b;
    repeat (n) @(posedge clock);
    irq_lines <= 10'h000;
  endtask
  // Hold length decides short press or power off
  task automatic press(input int n);
    @(posedge clock) pwr_btn <= 1'b1;
    repeat (n) @(posedge clock);
    pwr_btn <= 1'b0;
  endtask
  // Ring burst
  task automatic ring(input int n);
    @(posedge clock) ring_ind <= 1'b1;
    repeat (n) @(posedge clock);
    ring_ind <= 1'b0;
  endtask
  // Clock time changes only when told, like a real calendar read
  task automatic set_rtc(input logic [21:0] v);
    @(posedge clock) rtc <= v;
  endtask
endmodule

// ==== tb_system_power_state_manager.sv ====
// Self-checking bench of the power state manager.
// Assumes a short second tick so minute timeouts fit in the run.
`timescale 1ns/1ns
module tb_system_power_state_manager;
  import spm_pkg::*;
  localparam int TK = 20;
  localparam int MIN = 60 * TK;
  logic clock, rst_n, wr_en, rd_en, pwr_btn, ring_ind;
  logic sys_on, cpu_clk_en, standby_evt, suspend_evt, irq;
  logic [AW-1:0] addr;
  logic [31:0] wr_data, rd_data;
  logic [9:0] irq_lines, b;
  logic [21:0] rtc;
  spm_st_e power_state, exp_st;
  spm_pd_e video_mode, hdd_mode;
  spm_mon_e mon_st;
  int bad_count, total_checks, cyc, n;
  int mb[8] = '{1, 2, 4, 5, 6, 7, 8, 9};
  int rq[$] = '{0, 0, 4, 0, 8, 'h111, 'hC, 'h3F6, 'h10, 0,
    'h14, 'h0F0C321E, 'h20, 0, 'h24, 0};
  ////////////////////////////////////////////////////////////////////////////
  spm_power_mgr #(.TICK_CYCLES(TK)) DUT (.clock(clock), .rst_n(rst_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .irq_lines(irq_lines), .pwr_btn(pwr_btn),
    .ring_ind(ring_ind), .rtc_day(rtc[21:17]), .rtc_hour(rtc[16:12]),
    .rtc_min(rtc[11:6]), .rtc_sec(rtc[5:0]), .power_state(power_state),
    .sys_on(sys_on), .cpu_clk_en(cpu_clk_en), .video_mode(video_mode),
    .hdd_mode(hdd_mode), .monitor_saving_state(mon_st),
    .standby_evt(standby_evt), .suspend_evt(suspend_evt), .irq(irq));
  spm_far FAR (.clock(clock), .irq_lines(irq_lines), .pwr_btn(pwr_btn),
    .ring_ind(ring_ind), .rtc(rtc));
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clock) begin
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
    end
    @(posedge clock) wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
    @(posedge clock) begin
      rd_en <= 1'b1;
      addr <= a;
    end
    @(posedge clock) rd_en <= 1'b0;
    #1 chk(rd_data, e);
  endtask
  // Model state moves, then the design must reach it within lim cycles
  task automatic go(input spm_st_e s, input int lim);
    int k;
    exp_st = s;
    k = 0;
    // Step off the edge so a change launched there has settled
    #1;
    while (power_state !== exp_st && k < lim) begin
      wt(1);
      k++;
    end
    chk(32'(power_state), 32'(exp_st));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wr_data = '0;
    void'($urandom(71));
    b = 10'h001 << mb[$urandom % 8];
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < rq.size(); i += 2)
      rd(8'(rq[i]), 32'(rq[i + 1]));
    FAR.set_rtc({5'h01, 17'($urandom)});
    wr(A_TMO, 32'h11);
    wt(MIN + 100);
    go(ST_ON, 1);
    wr(A_CTRL, 32'h1);
    wr(A_ISTS, 32'h1F);
    wr(A_TMO, 32'h11);
    wt(MIN - 60);
    go(ST_ON, 1);
    go(ST_STBY, 120);
    chk(standby_evt, 1);
    // Device codes follow the state register by one cycle
    wt(1);
    chk(standby_evt, 0);
    chk(video_mode, PD_STBY);
    chk(hdd_mode, PD_NONE);
    chk(mon_st, MON_STBY);
    // Throttle: processor clock runs 5 of every 8 cycles
    n = 0;
    repeat (80) begin
      wt(1);
      if (cpu_clk_en === 1'b1) n++;
    end
    chk(n, 50);
    rd(A_ISTS, 32'h1 << EV_STBY);
    chk(irq, 0);
    wr(A_IMSK, 32'h1F);
    wt(2);
    chk(irq, 1);
    wr(A_ISTS, 32'h1F);
    wt(2);
    chk(irq, 0);
    go(ST_SUSP, MIN + 100);
    chk(suspend_evt, 1);
    FAR.act(10'h001, 40);
    go(ST_SUSP, 1);
    FAR.act(b, 4);
    go(ST_ON, 20);
    // Activity mid-count must push expiry out
    wr(A_TMO, 32'h1);
    wt(MIN - 300);
    FAR.act(b, 2);
    wt(400);
    go(ST_ON, 1);
    go(ST_STBY, MIN);
    FAR.act(b, 4);
    go(ST_ON, 20);
    wr(A_TMO, 32'h0);
    FAR.press(30);
    go(ST_SUSP, 20);
    FAR.act(b, 4);
    go(ST_ON, 20);
    FAR.press(6 * TK);
    go(ST_OFF, 1);
    chk(sys_on, 0);
    FAR.ring(10);
    wt(20);
    go(ST_OFF, 1);
    wr(A_WAKE, 32'h1);
    FAR.ring(10);
    go(ST_ON, 20);
    wr(A_WAKE, 32'h6);
    FAR.press(10);
    go(ST_OFF, 1);
    FAR.set_rtc({5'd15, 5'd12, 6'd50, 6'd30});
    go(ST_ON, 20);
    // Instant-on keeps the full clock; other device codes in standby
    wr(A_CTRL, 32'h0000_0002);
    wr(A_DEV, 32'h0000_00F6);
    rd(A_DEV, 32'h0000_00F6);
    wr(A_TMO, 32'h0000_0001);
    go(ST_STBY, MIN + 40);
    wt(1);
    chk(video_mode, PD_SUSP);
    chk(hdd_mode, PD_STBY);
    chk(mon_st, MON_OFF);
    n = 0;
    repeat (16) begin
      wt(1);
      if (cpu_clk_en === 1'b1) n++;
    end
    chk(n, 16);
    finish_test();
  end
endmodule
